// ==== pkg/oef_pkg.sv ====
`default_nettype none
package oef_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // function-level command codes
   localparam logic [7:0] CMD_READ_FIELD   = 8'hF0;
   localparam logic [7:0] CMD_WRITE_MEM    = 8'h0F;
   localparam logic [7:0] CMD_READ_STATUS  = 8'hAA;
   localparam logic [7:0] CMD_WRITE_STATUS = 8'h55;
   localparam logic [7:0] CMD_PROFILE      = 8'h99;
   localparam logic [7:0] CMD_PROGRAM      = 8'h5A;
   localparam logic [7:0] PROFILE_REPLY    = 8'h55;

   ////////////////////////////////////////////////////////////////////////////
   // memory geometry and values after reset
   localparam int          DATA_BYTES    = 192;
   localparam int          STATUS_BYTES  = 8;
   localparam int          SEG_BYTES     = 8;
   localparam logic [15:0] DATA_END      = 16'h00C0;
   localparam logic [15:0] STATUS_END    = 16'h0008;
   localparam logic [7:0]  BLANK_BYTE    = 8'hFF;
   localparam logic [63:0] STATUS_RESET  = 64'h00FF_FFFF_FFFF_FFFF;
   localparam logic [7:0]  CRC_SEED      = 8'h00;
   localparam logic [7:0]  CRC_POLY_REFL = 8'h8C;
   localparam logic [2:0]  LAST_BIT      = 3'h7;
   localparam int          FIFO_DEPTH    = 4;
   localparam int          BYTE_W        = 8;

   ////////////////////////////////////////////////////////////////////////////
   // engine states
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR_LO,
      ST_ADDR_HI,
      ST_SDATA,
      ST_SEND_CRC,
      ST_STREAM_D,
      ST_STREAM_S,
      ST_END_CRC,
      ST_WM_DATA,
      ST_CRC_OUT,
      ST_WAIT_PGM,
      ST_PROG_ARM,
      ST_PROG_HOLD,
      ST_VERIFY,
      ST_PROFILE,
      ST_ONES
   } oef_state_e;

   typedef struct packed {
      oef_state_e                        st;
      logic [7:0]                        cmd;
      logic [15:0]                       addr;
      logic [7:0]                        crc;
      logic [7:0]                        rx_sh;
      logic [2:0]                        rx_cnt;
      logic [SEG_BYTES-1:0][7:0]         stage;
      logic [2:0]                        stage_cnt;
      logic [7:0]                        sdata;
      logic                              pushed;
      logic [7:0]                        tx_sh;
      logic [2:0]                        tx_cnt;
      logic                              tx_have;
      logic                              tx_bit;
      logic                              prog_armed;
      logic [DATA_BYTES-1:0][7:0]        dmem;
      logic [STATUS_BYTES-1:0][7:0]      smem;
   } oef_core_s;

   ////////////////////////////////////////////////////////////////////////////
   // one byte into the crc, lsb first, x^8+x^5+x^4+1
   function automatic logic [7:0] crc_byte(input logic [7:0] c_in, input logic [7:0] d);
      logic [7:0] c;
      logic       fb;
      c  = c_in;
      fb = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         fb = c[0] ^ d[i];
         c  = {1'b0, c[7:1]};
         if (fb)
         begin
            c = c ^ CRC_POLY_REFL;
         end
      end
      return c;
   endfunction : crc_byte

endpackage : oef_pkg
`default_nettype wire

// ==== logic/oef_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
module oef_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         clr_i,
   // fill side
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   // drain side
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);

   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wr;
      logic [AW-1:0]       rd;
      logic [CW-1:0]       cnt;
   } oef_fifo_s;

   oef_fifo_s q_ff;
   oef_fifo_s nxt_q;
   logic      do_push;
   logic      do_pop;

   ////////////////////////////////////////////////////////////////////////////
   assign in_ready_o  = (q_ff.cnt != CW'(D));
   assign out_valid_o = (q_ff.cnt != '0);
   assign out_data_o  = q_ff.mem[q_ff.rd];

   always_comb
   begin
      nxt_q   = q_ff;
      do_push = in_valid_i && in_ready_o;
      do_pop  = out_valid_o && out_ready_i;
      if (do_push)
      begin
         nxt_q.mem[q_ff.wr] = in_data_i;
         nxt_q.wr = (q_ff.wr == AW'(D - 1)) ? '0 : AW'(q_ff.wr + 1'b1);
      end
      if (do_pop)
      begin
         nxt_q.rd = (q_ff.rd == AW'(D - 1)) ? '0 : AW'(q_ff.rd + 1'b1);
      end
      case ({do_push, do_pop})
         2'b10:   nxt_q.cnt = CW'(q_ff.cnt + 1'b1);
         2'b01:   nxt_q.cnt = CW'(q_ff.cnt - 1'b1);
         default: nxt_q.cnt = q_ff.cnt;
      endcase
      // flush drops queued words, storage itself needs no clearing
      if (clr_i)
      begin
         nxt_q.wr  = '0;
         nxt_q.rd  = '0;
         nxt_q.cnt = '0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         q_ff <= '0;
      end
      else
      begin
         q_ff <= nxt_q;
      end
   end

endmodule : oef_fifo
`default_nettype wire

// ==== logic/oef_core.sv ====
// Behaviour
// - write-memory code, address low, address high; answer crc over all three.
// - memory programmed in eight-byte segments, bytes staged one by one first.
// - after address crc take eight data bytes, answer fresh crc over them.
// - programming ANDs staging buffer into the eight-byte segment holding start address.
// - reset pulse aborts write-memory anywhere, during programming pulse too.
// - unprogrammed data memory reads all ones.
// - device never checks host crc agreement, never blocks a sequence.
// - field read: crc over command and address, bytes to end, closing crc.
// - status read code plus two address bytes; crc over those three.
// - status bytes from address to field end, then crc over sent bytes.
// - after closing status crc all reads are ones until reset pulse.
// - status write code, address, data byte; crc over all four.
// - after program pulse clear status bits where data byte bit is zero.
// - first seven status bytes blank ones, eighth fixed at zero.
// - after pulse, eight read slots return selected status byte lsb first.
// - after verify slots increment address, load its low byte into crc.
// - next data byte shifted into preloaded crc, result returned.
// - every address and data byte travels lsb first.
// - program code decoded only in write modes; codes are function level.
// - every crc uses x^8+x^5+x^4+1, one bit at a time.
// - profile query answered with a fixed byte.
// - long low wire resets device, engine returns to idle.
// - function commands accepted only once selected at selection level.
`timescale 1ns/1ns
`default_nettype none
module oef_core (
   // clock and reset
   input  wire logic CLOCK_I,
   input  wire logic RESET_N_I,
   // link layer events
   input  wire logic RESET_PULSE_I,
   input  wire logic SELECTED_I,
   input  wire logic SLOT_WR_I,
   input  wire logic SLOT_BIT_I,
   input  wire logic SLOT_RD_I,
   input  wire logic PROG_ACTIVE_I,
   // answers to the link layer
   output logic      TX_BIT_O,
   output logic      PROG_ARMED_O
);

   oef_pkg::oef_core_s q_ff;
   oef_pkg::oef_core_s nxt_q;

   logic       rx_done;
   logic [7:0] rx_byte;
   logic       tx_done;
   logic       push_v;
   logic [7:0] push_d;
   logic       push_rdy;
   logic       pop_v;
   logic       pop_rdy;
   logic [7:0] pop_d;
   logic       frozen;
   logic [7:0] base;

   ////////////////////////////////////////////////////////////////////////////
   // outgoing bytes queue ahead so read slots never wait on the engine
   oef_fifo #(
      .W (oef_pkg::BYTE_W),
      .D (oef_pkg::FIFO_DEPTH)
   ) u_txq (
      .clk_i       (CLOCK_I),
      .rst_n_i     (RESET_N_I),
      .clr_i       (RESET_PULSE_I),
      .in_valid_i  (push_v),
      .in_ready_o  (push_rdy),
      .in_data_i   (push_d),
      .out_valid_o (pop_v),
      .out_ready_i (pop_rdy),
      .out_data_o  (pop_d)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      nxt_q   = q_ff;
      rx_done = 1'b0;
      rx_byte = {SLOT_BIT_I, q_ff.rx_sh[7:1]};
      tx_done = 1'b0;
      push_v  = 1'b0;
      push_d  = oef_pkg::BLANK_BYTE;
      pop_rdy = 1'b0;
      base    = {q_ff.addr[7:3], 3'h0};
      // wire at programming level: no slots, no state change outside ST_PROG_ARM and ST_PROG_HOLD except by a wire reset pulse
      frozen  = PROG_ACTIVE_I;

      // write slots assemble a byte lsb first
      if (SLOT_WR_I && !frozen)
      begin
         nxt_q.rx_sh  = rx_byte;
         nxt_q.rx_cnt = q_ff.rx_cnt + 3'h1;
         rx_done      = (q_ff.rx_cnt == oef_pkg::LAST_BIT);
      end

      // read slots shift the queued byte out lsb first, ones when empty
      if (SLOT_RD_I && !frozen && q_ff.tx_have)
      begin
         nxt_q.tx_sh  = {1'b1, q_ff.tx_sh[7:1]};
         nxt_q.tx_cnt = q_ff.tx_cnt + 3'h1;
         if (q_ff.tx_cnt == oef_pkg::LAST_BIT)
         begin
            nxt_q.tx_have = 1'b0;
            tx_done       = 1'b1;
         end
      end
      if (!nxt_q.tx_have && pop_v && !frozen)
      begin
         pop_rdy       = 1'b1;
         nxt_q.tx_sh   = pop_d;
         nxt_q.tx_cnt  = 3'h0;
         nxt_q.tx_have = 1'b1;
      end

      case (q_ff.st)
         oef_pkg::ST_IDLE:
         begin
            if (rx_done && SELECTED_I)
            begin
               nxt_q.cmd = rx_byte;
               nxt_q.crc = oef_pkg::crc_byte(oef_pkg::CRC_SEED, rx_byte);
               // these codes mean function commands only at this level
               case (rx_byte)
                  oef_pkg::CMD_READ_FIELD,
                  oef_pkg::CMD_WRITE_MEM,
                  oef_pkg::CMD_READ_STATUS,
                  oef_pkg::CMD_WRITE_STATUS: nxt_q.st = oef_pkg::ST_ADDR_LO;
                  oef_pkg::CMD_PROFILE:      nxt_q.st = oef_pkg::ST_PROFILE;
                  default:                   nxt_q.st = oef_pkg::ST_ONES;
               endcase
            end
         end
         oef_pkg::ST_ADDR_LO:
         begin
            if (rx_done)
            begin
               nxt_q.addr[7:0] = rx_byte;
               nxt_q.crc       = oef_pkg::crc_byte(q_ff.crc, rx_byte);
               nxt_q.st        = oef_pkg::ST_ADDR_HI;
            end
         end
         oef_pkg::ST_ADDR_HI:
         begin
            if (rx_done)
            begin
               nxt_q.addr[15:8] = rx_byte;
               nxt_q.crc        = oef_pkg::crc_byte(q_ff.crc, rx_byte);
               nxt_q.st         = (q_ff.cmd == oef_pkg::CMD_WRITE_STATUS) ?
                                  oef_pkg::ST_SDATA : oef_pkg::ST_SEND_CRC;
            end
         end
         oef_pkg::ST_SDATA:
         begin
            if (rx_done)
            begin
               nxt_q.sdata = rx_byte;
               nxt_q.crc   = oef_pkg::crc_byte(q_ff.crc, rx_byte);
               nxt_q.st    = oef_pkg::ST_SEND_CRC;
            end
         end
         oef_pkg::ST_SEND_CRC:
         begin
            push_v = 1'b1;
            push_d = q_ff.crc;
            if (push_rdy)
            begin
               // data crc starts afresh; host alone judges the answer
               nxt_q.crc       = oef_pkg::CRC_SEED;
               nxt_q.stage_cnt = 3'h0;
               case (q_ff.cmd)
                  oef_pkg::CMD_READ_FIELD:  nxt_q.st = oef_pkg::ST_STREAM_D;
                  oef_pkg::CMD_READ_STATUS: nxt_q.st = oef_pkg::ST_STREAM_S;
                  oef_pkg::CMD_WRITE_MEM:   nxt_q.st = oef_pkg::ST_WM_DATA;
                  default:                  nxt_q.st = oef_pkg::ST_WAIT_PGM;
               endcase
            end
         end
         oef_pkg::ST_STREAM_D:
         begin
            if (q_ff.addr >= oef_pkg::DATA_END)
            begin
               nxt_q.st = oef_pkg::ST_END_CRC;
            end
            else
            begin
               push_v = 1'b1;
               push_d = q_ff.dmem[q_ff.addr[7:0]];
               if (push_rdy)
               begin
                  nxt_q.crc  = oef_pkg::crc_byte(q_ff.crc, push_d);
                  nxt_q.addr = q_ff.addr + 16'h0001;
               end
            end
         end
         oef_pkg::ST_STREAM_S:
         begin
            if (q_ff.addr >= oef_pkg::STATUS_END)
            begin
               nxt_q.st = oef_pkg::ST_END_CRC;
            end
            else
            begin
               push_v = 1'b1;
               push_d = q_ff.smem[q_ff.addr[2:0]];
               if (push_rdy)
               begin
                  nxt_q.crc  = oef_pkg::crc_byte(q_ff.crc, push_d);
                  nxt_q.addr = q_ff.addr + 16'h0001;
               end
            end
         end
         oef_pkg::ST_END_CRC:
         begin
            push_v = 1'b1;
            push_d = q_ff.crc;
            if (push_rdy)
            begin
               nxt_q.st = oef_pkg::ST_ONES;
            end
         end
         oef_pkg::ST_WM_DATA:
         begin
            if (rx_done)
            begin
               nxt_q.stage[q_ff.stage_cnt] = rx_byte;
               nxt_q.stage_cnt = q_ff.stage_cnt + 3'h1;
               nxt_q.crc       = oef_pkg::crc_byte(q_ff.crc, rx_byte);
               if (q_ff.stage_cnt == oef_pkg::LAST_BIT)
               begin
                  nxt_q.st = oef_pkg::ST_CRC_OUT;
               end
            end
         end
         oef_pkg::ST_CRC_OUT:
         begin
            push_v = 1'b1;
            push_d = q_ff.crc;
            if (push_rdy)
            begin
               nxt_q.st = oef_pkg::ST_WAIT_PGM;
            end
         end
         oef_pkg::ST_WAIT_PGM:
         begin
            if (rx_done)
            begin
               // program code has meaning only here
               if (rx_byte == oef_pkg::CMD_PROGRAM)
               begin
                  nxt_q.st         = oef_pkg::ST_PROG_ARM;
                  nxt_q.prog_armed = 1'b1;
               end
               else
               begin
                  nxt_q.st = oef_pkg::ST_ONES;
               end
            end
         end
         oef_pkg::ST_PROG_ARM:
         begin
            if (PROG_ACTIVE_I)
            begin
               nxt_q.st = oef_pkg::ST_PROG_HOLD;
               if (q_ff.cmd == oef_pkg::CMD_WRITE_MEM)
               begin
                  // out-of-range segments program nothing
                  if (q_ff.addr < oef_pkg::DATA_END)
                  begin
                     for (int i = 0; i < oef_pkg::SEG_BYTES; i++)
                     begin
                        nxt_q.dmem[base + 8'(i)] = q_ff.dmem[base + 8'(i)] &
                                                   q_ff.stage[i];
                     end
                  end
               end
               else if (q_ff.addr < oef_pkg::STATUS_END)
               begin
                  nxt_q.smem[q_ff.addr[2:0]] = q_ff.smem[q_ff.addr[2:0]] &
                                               q_ff.sdata;
               end
            end
         end
         oef_pkg::ST_PROG_HOLD:
         begin
            // resume only once the wire is back at idle level
            if (!PROG_ACTIVE_I)
            begin
               nxt_q.prog_armed = 1'b0;
               nxt_q.pushed     = 1'b0;
               nxt_q.st         = (q_ff.cmd == oef_pkg::CMD_WRITE_STATUS) ?
                                  oef_pkg::ST_VERIFY : oef_pkg::ST_ONES;
            end
         end
         oef_pkg::ST_VERIFY:
         begin
            if (!q_ff.pushed)
            begin
               push_v = 1'b1;
               push_d = q_ff.smem[q_ff.addr[2:0]];
               nxt_q.pushed = push_rdy;
            end
            else if (tx_done)
            begin
               // increment is unconditional, whatever the host saw
               nxt_q.addr = q_ff.addr + 16'h0001;
               nxt_q.crc  = 8'(q_ff.addr + 16'h0001);
               // next byte reuses the data path: crc shift, answer, then wait for program code
               nxt_q.st   = oef_pkg::ST_SDATA;
            end
         end
         oef_pkg::ST_PROFILE:
         begin
            push_v = 1'b1;
            push_d = oef_pkg::PROFILE_REPLY;
            if (push_rdy)
            begin
               nxt_q.st = oef_pkg::ST_ONES;
            end
         end
         oef_pkg::ST_ONES:
         begin
            nxt_q.st = oef_pkg::ST_ONES;
         end
         default:
         begin
            nxt_q.st = oef_pkg::ST_ONES;
         end
      endcase

      // frozen hold keeps every field while the pulse lasts, except in ST_PROG_ARM and ST_PROG_HOLD; a wire reset pulse below still overrides it
      if (frozen && (q_ff.st != oef_pkg::ST_PROG_ARM) && (q_ff.st != oef_pkg::ST_PROG_HOLD))
      begin
         nxt_q  = q_ff;
         push_v = 1'b0;
      end

      // wire reset pulse ends any sequence; eprom contents survive
      if (RESET_PULSE_I)
      begin
         nxt_q.st         = oef_pkg::ST_IDLE;
         nxt_q.rx_cnt     = 3'h0;
         nxt_q.tx_have    = 1'b0;
         nxt_q.tx_cnt     = 3'h0;
         nxt_q.prog_armed = 1'b0;
         nxt_q.pushed     = 1'b0;
         push_v           = 1'b0;
         pop_rdy          = 1'b0;
      end
      nxt_q.tx_bit = nxt_q.tx_have ? nxt_q.tx_sh[0] : 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLOCK_I)
   begin
      if (!RESET_N_I)
      begin
         q_ff        <= '0;
         q_ff.st     <= oef_pkg::ST_IDLE;
         q_ff.tx_bit <= 1'b1;
         q_ff.dmem   <= '1;
         q_ff.smem   <= oef_pkg::STATUS_RESET;
      end
      else
      begin
         q_ff <= nxt_q;
      end
   end

   assign TX_BIT_O     = q_ff.tx_bit;
   assign PROG_ARMED_O = q_ff.prog_armed;

endmodule : oef_core
`default_nettype wire

// ==== sim/oef_core_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module oef_core_props (
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic RESET_N_I,
   // link layer events
   input wire logic RESET_PULSE_I,
   input wire logic SELECTED_I,
   input wire logic SLOT_WR_I,
   input wire logic SLOT_BIT_I,
   input wire logic SLOT_RD_I,
   input wire logic PROG_ACTIVE_I,
   // answers
   input wire logic TX_BIT_O,
   input wire logic PROG_ARMED_O
);
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (!RESET_N_I);
   ////////////////////////////////////////
   sequence s_arm_pulse;
      PROG_ARMED_O && PROG_ACTIVE_I;
   endsequence
   sequence s_zero_held;
      !TX_BIT_O && !SLOT_RD_I && !$past(SLOT_RD_I) && !RESET_PULSE_I && !$past(RESET_PULSE_I);
   endsequence
   ////////////////////////////////////////
   property p_arm_src;
      $rose(PROG_ARMED_O) |-> !$past(PROG_ACTIVE_I)
         && ($past(SLOT_WR_I) || $past(SLOT_WR_I, 2) || $past(SLOT_WR_I, 3));
   endproperty
   a_arm_src: assert property (p_arm_src) else $error("arm without a write");
   property p_arm_hold;
      s_arm_pulse |=> PROG_ARMED_O;
   endproperty
   a_arm_hold: assert property (p_arm_hold) else $error("arm lost in pulse");
   property p_arm_drop;
      $fell(PROG_ACTIVE_I) |-> ##[0:2] !PROG_ARMED_O;
   endproperty
   a_arm_drop: assert property (p_arm_drop) else $error("arm kept after pulse");
   property p_tx_freeze;
      PROG_ACTIVE_I && $past(PROG_ACTIVE_I) |-> $stable(TX_BIT_O);
   endproperty
   a_tx_freeze: assert property (p_tx_freeze) else $error("tx moved in pulse");
   property p_tx_stands;
      s_zero_held |=> !TX_BIT_O;
   endproperty
   a_tx_stands: assert property (p_tx_stands) else $error("tx bit moved unread");
   property p_wreset;
      RESET_PULSE_I |-> ##2 TX_BIT_O && !PROG_ARMED_O;
   endproperty
   a_wreset: assert property (p_wreset) else $error("wire reset not idle");
   property p_rst_rel;
      $rose(RESET_N_I) |-> TX_BIT_O && !PROG_ARMED_O;
   endproperty
   a_rst_rel: assert property (p_rst_rel) else $error("bad state after reset");
   property p_arm_quiet;
      PROG_ARMED_O |-> TX_BIT_O;
   endproperty
   a_arm_quiet: assert property (p_arm_quiet) else $error("answer while armed");
endmodule : oef_core_props
`default_nettype wire

// ==== sim/oef_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module oef_host_model #(
   // shortened pulse: the design follows the level only
   parameter int PULSE_CYC = 40
) (
   input  wire logic clk_i,
   input  wire logic tx_i,
   output var logic  wreset_o,
   output var logic  wr_o,
   output var logic  bit_o,
   output var logic  rd_o,
   output var logic  prog_o
);
   initial
   begin
      wreset_o = 1'b0;
      wr_o     = 1'b0;
      bit_o    = 1'b1;
      rd_o     = 1'b0;
      prog_o   = 1'b0;
   end
   ////////////////////////////////////////
   task automatic wr_byte(input logic [7:0] b);
      for (int i = 0; i < 8; i++)
      begin
         @(negedge clk_i);
         wr_o  = 1'b1;
         bit_o = b[i];
         @(negedge clk_i);
         wr_o  = 1'b0;
         bit_o = 1'b1; // idle wire is pulled up
      end
   endtask : wr_byte
   task automatic rd_byte(output logic [7:0] b);
      repeat (6) @(negedge clk_i);
      for (int i = 0; i < 8; i++)
      begin
         b[i] = tx_i;
         rd_o = 1'b1;
         @(negedge clk_i);
         rd_o = 1'b0;
         repeat (2) @(negedge clk_i);
      end
   endtask : rd_byte
   task automatic pulse();
      @(negedge clk_i);
      prog_o = 1'b1;
      repeat (PULSE_CYC) @(negedge clk_i);
      prog_o = 1'b0;
      repeat (3) @(negedge clk_i);
   endtask : pulse
   task automatic wire_reset();
      @(negedge clk_i);
      wreset_o = 1'b1;
      @(negedge clk_i);
      wreset_o = 1'b0;
      repeat (2) @(negedge clk_i);
   endtask : wire_reset
endmodule : oef_host_model
`default_nettype wire

// ==== sim/tb_oef_core.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_oef_core;
   logic       clk;
   logic       rst_n;
   logic       sel;
   logic       wrst;
   logic       wr;
   logic       wb;
   logic       rd;
   logic       prog;
   logic       tx;
   logic       armed;
   int         errors;
   int         cmp_count;
   int         cyc;
   logic [7:0] em [192];
   logic [7:0] es [8];
   logic [7:0] v;
   logic [7:0] k;
   ////////////////////////////////////////
   oef_core DUT (.CLOCK_I(clk), .RESET_N_I(rst_n), .RESET_PULSE_I(wrst), .SELECTED_I(sel),
      .SLOT_WR_I(wr), .SLOT_BIT_I(wb), .SLOT_RD_I(rd), .PROG_ACTIVE_I(prog),
      .TX_BIT_O(tx), .PROG_ARMED_O(armed));
   oef_host_model host (.clk_i(clk), .tx_i(tx), .wreset_o(wrst), .wr_o(wr), .bit_o(wb),
      .rd_o(rd), .prog_o(prog));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   ////////////////////////////////////////
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
      begin
         r = (r[0] ^ d[i]) ? ({1'b0, r[7:1]} ^ 8'h8C) : {1'b0, r[7:1]};
      end
      return r;
   endfunction : crc8
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e)
      begin
         errors++;
         $display("Error at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] e);
      host.rd_byte(v);
      chk(v, e);
   endtask : rdc
   task automatic cmd3(input logic [7:0] c, input logic [15:0] a);
      host.wr_byte(c);
      host.wr_byte(a[7:0]);
      host.wr_byte(a[15:8]);
      k = crc8(crc8(crc8(8'h00, c), a[7:0]), a[15:8]);
   endtask : cmd3
   ////////////////////////////////////////
   task automatic t_profile();
      host.wr_byte(8'h99);
      rdc(8'h55);
      rdc(8'hFF);
      host.wire_reset();
   endtask : t_profile
   task automatic t_sread(input int a);
      cmd3(8'hAA, 16'(a));
      rdc(k);
      k = 8'h00;
      for (int i = a; i < 8; i++)
      begin
         rdc(es[i]);
         k = crc8(k, es[i]);
      end
      rdc(k);
      rdc(8'hFF);
      host.wire_reset();
   endtask : t_sread
   task automatic t_wm(input logic [15:0] a, input logic [63:0] d);
      cmd3(8'h0F, a);
      rdc(k);
      k = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         host.wr_byte(d[8*i+:8]);
         k = crc8(k, d[8*i+:8]);
         em[a+i] = em[a+i] & d[8*i+:8];
      end
      rdc(k);
      host.wr_byte(8'h5A);
      repeat (4) @(negedge clk);
      chk({7'h00, armed}, 8'h01);
      host.pulse();
      chk({7'h00, armed}, 8'h00);
      host.wire_reset();
   endtask : t_wm
   task automatic t_fread(input int a);
      cmd3(8'hF0, 16'(a));
      rdc(k);
      k = 8'h00;
      for (int i = a; i < 192; i++)
      begin
         rdc(em[i]);
         k = crc8(k, em[i]);
      end
      rdc(k);
      rdc(8'hFF);
      host.wire_reset();
   endtask : t_fread
   task automatic t_swrite();
      cmd3(8'h55, 16'h0006);
      host.wr_byte(8'hA5);
      rdc(crc8(k, 8'hA5));
      host.wr_byte(8'h5A);
      host.pulse();
      es[6] = es[6] & 8'hA5;
      rdc(es[6]);
      host.wr_byte(8'h3C);
      rdc(crc8(8'h07, 8'h3C));
      host.wr_byte(8'h5A);
      host.pulse();
      rdc(es[7]);
      host.wire_reset();
   endtask : t_swrite
   task automatic t_misc();
      sel = 1'b0;
      host.wr_byte(8'h99);
      rdc(8'hFF);
      sel = 1'b1;
      host.wire_reset();
      host.wr_byte(8'h5A);
      rdc(8'hFF);
      host.wire_reset();
      cmd3(8'h0F, 16'h00B0);
      rdc(k);
      host.wr_byte(8'h12);
      host.wire_reset();
      cmd3(8'h55, 16'h0000);
      host.wr_byte(8'hFF);
      rdc(crc8(k, 8'hFF));
      host.wr_byte(8'h00);
      repeat (4) @(negedge clk);
      chk({7'h00, armed}, 8'h00);
      rdc(8'hFF);
      host.wire_reset();
      t_profile();
   endtask : t_misc
   ////////////////////////////////////////
   task automatic print_verdict();
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   // ceiling well above the few thousand cycles the run needs
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         errors++;
         print_verdict();
      end
   end
   initial
   begin
      errors = 0;
      cmp_count = 0;
      cyc = 0;
      rst_n = 1'b0;
      sel = 1'b1;
      foreach (em[i]) em[i] = 8'hFF;
      foreach (es[i]) es[i] = (i == 7) ? 8'h00 : 8'hFF;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      t_profile();
      t_sread(5);
      t_wm(16'h00B8, 64'h0123_4567_89AB_CDEF);
      t_wm(16'h00B8, 64'hF0F0_3C3C_FF00_5A5A);
      t_fread(16'h00B0);
      t_swrite();
      t_sread(0);
      t_misc();
      print_verdict();
   end
endmodule : tb_oef_core
bind oef_core oef_core_props u_props (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I),
   .RESET_PULSE_I(RESET_PULSE_I), .SELECTED_I(SELECTED_I), .SLOT_WR_I(SLOT_WR_I),
   .SLOT_BIT_I(SLOT_BIT_I), .SLOT_RD_I(SLOT_RD_I), .PROG_ACTIVE_I(PROG_ACTIVE_I),
   .TX_BIT_O(TX_BIT_O), .PROG_ARMED_O(PROG_ARMED_O));
`default_nettype wire
